// [rtl/coc_cfg.svh]
`ifndef COC_CFG_SVH
`define COC_CFG_SVH

// Reset values of the control bits
`define COC_RST_BIT           1'b0
// Shared result register width and this comparator's lane in it
`define COC_SHARED_WIDTH      2
`define COC_SHARED_LANE       0
// Pin output selector code that routes the comparator to the pin
`define COC_PIN_SEL_WIDTH     5
`define COC_PIN_SEL_CODE      5'h15
// Instruction cycle length in system clocks
`define COC_INSTR_DIV         4
`define COC_INSTR_CNT_WIDTH   2

`endif

// [rtl/coc_pkg.sv]
`include "coc_cfg.svh"

package coc_pkg;

    typedef logic [`COC_INSTR_CNT_WIDTH-1:0] coc_div_t;
    typedef logic [`COC_PIN_SEL_WIDTH-1:0]   coc_sel_t;

endpackage

// [rtl/coc_comparator_output_control.sv]
// What this block does
// [R1] Comparator runs only while enable is set; clear means off, lowest current.
// [R2] Raw result low when noninverting input below inverting, high when above.
// [R3] Invert select one complements raw result; zero passes it unchanged.
// [R4] Adjusted result readable as result bit and shared register mirror bit.
// [R5] Internal output latched each instruction cycle; pin output not latched.
// [R6] Output selectable for pin via output selector; needs direction set output.
// [R7] Hysteresis select set enables analog hysteresis while enable is set; clear or disabled turns it off.
// [R8] Output offered to gate timer as a gate control source.
// [R9] Sync select set registers output on gate timer clock falling edge.
// [R10] With prescaler, sync register uses falling edge of prescaled clock.
// [R11] Gate timer counts on rising clock edge, opposite the sync edge.
// [R12] Software should enable sync whenever the comparator gates the timer.
// [R13] Sync clear passes output unsynchronised; set updates on timer falling edge.
// [R14] Event flag set on enabled rising or falling edge of the result bit.
// [R15] Event flag cleared only by software or reset; a simultaneous edge keeps it set.
// [R16] Invert or enable toggles change output and flag edges even when disabled.
// [R17] Reset clears all control bits: disabled, unsynchronised, non-inverted, low.
`timescale 1ns/100ps
`default_nettype none
`include "coc_cfg.svh"

module coc_comparator_output_control
    import coc_pkg::*;
#(
    parameter int INSTR_DIV = `COC_INSTR_DIV
) (
    // Clock and reset
    input  wire logic                          sys_clk,
    input  wire logic                          rst_n,
    // Software control bits
    input  wire logic                          comparator_enable_bit,
    input  wire logic                          invert_select,
    input  wire logic                          hysteresis_select,
    input  wire logic                          timer_sync_select,
    input  wire logic                          rising_flag_enable,
    input  wire logic                          falling_flag_enable,
    input  wire logic                          flag_clear,
    // Analog front end
    input  wire logic                          analog_compare,
    output logic                               analog_enable,
    output logic                               analog_hysteresis,
    // Gate timer clock, already prescaled where a prescaler is used
    input  wire logic                          timer_clk_in,
    // Pin routing
    input  wire logic [`COC_PIN_SEL_WIDTH-1:0] pin_output_selector,
    input  wire logic                          pin_direction_control,
    output logic                               pin_out,
    output logic                               pin_oe,
    // Results
    output logic                               result_bit,
    output logic [`COC_SHARED_WIDTH-1:0]       shared_result_register,
    output logic                               gate_source,
    output logic                               comparator_event_flag
);

    // Divider clears at INSTR_DIV-1; only INSTR_DIV equal to the full counter range is accepted
    if (INSTR_DIV != (1 << `COC_INSTR_CNT_WIDTH)) begin : g_bad_div
        $error("INSTR_DIV must match the divider width");
    end

    ////////////////////////////////////////////////////////////////////////
    // Input synchronisers and polarity

    logic [2:0] cmp_sync;
    logic [2:0] tclk_sync;
    logic       cmp_q;
    logic       tclk_q;
    logic [2:0] next_cmp_sync;
    logic [2:0] next_tclk_sync;
    logic       next_cmp_q;
    logic       next_tclk_q;
    logic       raw_result;
    logic       adj_result;
    logic       tclk_fall;

    always_comb begin
        next_cmp_sync  = {cmp_sync[1:0], analog_compare};
        next_tclk_sync = {tclk_sync[1:0], timer_clk_in};
        next_cmp_q     = cmp_q;
        next_tclk_q    = tclk_q;
        if (cmp_sync[1] == cmp_sync[2]) begin
            next_cmp_q = cmp_sync[2];
        end
        if (tclk_sync[1] == tclk_sync[2]) begin
            next_tclk_q = tclk_sync[2];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            cmp_sync  <= 3'h0;
            tclk_sync <= 3'h0;
            cmp_q     <= `COC_RST_BIT;
            tclk_q    <= `COC_RST_BIT;
        end else begin
            cmp_sync  <= next_cmp_sync;
            tclk_sync <= next_tclk_sync;
            cmp_q     <= next_cmp_q;
            tclk_q    <= next_tclk_q;
        end
    end

    // Disabled comparator reads low before polarity
    assign raw_result = comparator_enable_bit & cmp_q;   // [R1] [R2]
    assign adj_result = raw_result ^ invert_select;      // [R3] [R16]
    // Falling edge of the (prescaled) timer clock
    assign tclk_fall  = tclk_q & ~next_tclk_q;           // [R9] [R10]

    ////////////////////////////////////////////////////////////////////////
    // Instruction cycle latch, timer sync, edge flag

    coc_div_t div_cnt;
    coc_div_t next_div_cnt;
    logic     latched;
    logic     next_latched;
    logic     synced;
    logic     next_synced;
    logic     prev_latched;
    logic     next_prev_latched;
    logic     flag;
    logic     next_flag;
    logic     ext_out;
    logic     edge_hit;
    logic     instr_tick;

    assign instr_tick = (div_cnt == coc_div_t'(INSTR_DIV - 1));

    always_comb begin
        next_div_cnt      = instr_tick ? '0 : coc_div_t'(div_cnt + 1'b1);
        next_latched      = instr_tick ? adj_result : latched;          // [R5]
        next_synced       = tclk_fall ? adj_result : synced;            // [R9] [R10]
        next_prev_latched = latched;
        edge_hit = (rising_flag_enable & latched & ~prev_latched)
                 | (falling_flag_enable & ~latched & prev_latched);     // [R14] [R16]
        next_flag = flag;
        if (flag_clear) begin
            next_flag = 1'b0;                                           // [R15]
        end
        if (edge_hit) begin
            next_flag = 1'b1;                                           // [R15]
        end
        // Unsynchronised path is not latched
        ext_out = timer_sync_select ? next_synced : adj_result;         // [R13]
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            div_cnt      <= '0;
            latched      <= `COC_RST_BIT;
            synced       <= `COC_RST_BIT;
            prev_latched <= `COC_RST_BIT;
            flag         <= `COC_RST_BIT;
        end else begin
            div_cnt      <= next_div_cnt;
            latched      <= next_latched;
            synced       <= next_synced;
            prev_latched <= next_prev_latched;
            flag         <= next_flag;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output registers

    logic                         next_pin_out;
    logic                         next_pin_oe;
    logic [`COC_SHARED_WIDTH-1:0] next_shared;

    always_comb begin
        next_shared = '0;
        next_shared[`COC_SHARED_LANE] = next_latched;                   // [R4]
        next_pin_oe  = (pin_output_selector == `COC_PIN_SEL_CODE)
                     & ~pin_direction_control;                          // [R6]
        next_pin_out = next_pin_oe & ext_out;                           // [R6]
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            analog_enable          <= `COC_RST_BIT;
            analog_hysteresis      <= `COC_RST_BIT;
            pin_out                <= `COC_RST_BIT;
            pin_oe                 <= `COC_RST_BIT;
            result_bit             <= `COC_RST_BIT;
            shared_result_register <= '0;
            gate_source            <= `COC_RST_BIT;
            comparator_event_flag  <= `COC_RST_BIT;                     // [R17]
        end else begin
            analog_enable          <= comparator_enable_bit;            // [R1]
            analog_hysteresis      <= hysteresis_select & comparator_enable_bit; // [R7]
            pin_out                <= next_pin_out;
            pin_oe                 <= next_pin_oe;
            result_bit             <= next_latched;                     // [R4]
            shared_result_register <= next_shared;
            gate_source            <= ext_out;                          // [R8] [R11] [R12]
            comparator_event_flag  <= next_flag;
        end
    end

endmodule
`default_nettype wire

// [sim/coc_chk_assertions.sv]
`timescale 1ns/100ps
`default_nettype none
`include "coc_cfg.svh"
module coc_chk #(parameter int INSTR_DIV = 4) (
    // Controls
    input wire logic sys_clk, rst_n, timer_sync_select, timer_clk_in, pin_direction_control,
    input wire logic rising_flag_enable, falling_flag_enable, flag_clear,
    // Outputs
    input wire logic pin_out, pin_oe, result_bit, gate_source, comparator_event_flag,
    input wire logic [`COC_SHARED_WIDTH-1:0] shared_result_register
);
    wire ev = comparator_event_flag;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    a_mirror_bit: assert property (shared_result_register == {1'b0, result_bit})
        else $error("mirror bit wrong");
    a_pin_source: assert property (pin_oe |-> pin_out == gate_source)
        else $error("pin source wrong");
    a_pin_off: assert property (pin_direction_control |=> !pin_oe)
        else $error("pin driven as input");
    a_flag_keep: assert property (ev && !flag_clear |=> ev)
        else $error("flag lost");
    a_rise_flag: assert property ($rose(result_bit) && rising_flag_enable |=> ev)
        else $error("rise not flagged");
    a_fall_flag: assert property ($fell(result_bit) && falling_flag_enable |=> ev)
        else $error("fall not flagged");
    a_latch_hold: assert property ($changed(result_bit) |=> $stable(result_bit) [*3])
        else $error("result not latched");
    a_set_wins: assert property (flag_clear && (($rose(result_bit) && rising_flag_enable)
        || ($fell(result_bit) && falling_flag_enable)) |=> ev) else $error("clear beat edge");
    a_sync_hold: assert property ((timer_sync_select && $stable(timer_clk_in)) [*8]
        |-> $stable(gate_source)) else $error("gate moved without timer edge");
    c_flag: cover property ($rose(ev));
    c_sync: cover property (timer_sync_select && $changed(gate_source));
    c_pin: cover property (pin_oe && pin_out);
endmodule
bind coc_comparator_output_control coc_chk #(.INSTR_DIV(INSTR_DIV)) u_chk (.*);
`default_nettype wire

// [sim/coc_far_model.sv]
`timescale 1ns/100ps
`default_nettype none
module coc_far_model (
    // Bench side
    input wire logic sys_clk, level, run_clk, gate_source,
    // Toward the block
    output logic analog_compare, timer_clk_in
);
    int div = 0;
    int count = 0;
    initial {analog_compare, timer_clk_in} = 2'b00;
    // Timer clock stands still unless run
    always @(posedge sys_clk) begin
        analog_compare <= level;
        div <= run_clk ? (div + 1) % 5 : 0;
        if (run_clk && div == 4) timer_clk_in <= !timer_clk_in;
        if (run_clk && div == 4 && !timer_clk_in && gate_source) count <= count + 1;
    end
endmodule
`default_nettype wire

// [sim/tb.sv]
`timescale 1ns/100ps
`default_nettype none
`include "coc_cfg.svh"
module tb;
    import coc_pkg::*;
    logic sys_clk = 0, rst_n = 0, comparator_enable_bit = 0, invert_select = 0, flag_clear = 0;
    logic hysteresis_select = 1, timer_sync_select = 0, rising_flag_enable = 1, level = 0;
    logic falling_flag_enable = 0, pin_direction_control = 0, run_clk = 0, analog_compare;
    logic timer_clk_in, analog_enable, analog_hysteresis, pin_out, pin_oe, result_bit;
    logic gate_source, comparator_event_flag;
    logic [`COC_SHARED_WIDTH-1:0] shared_result_register;
    coc_sel_t pin_output_selector = `COC_PIN_SEL_CODE;
    logic [3:0] rows [6] = '{4'h8, 4'hB, 4'hE, 4'hD, 4'h2, 4'h7};
    int n_fail = 0;
    int check_count = 0;
    always #2 sys_clk = ~sys_clk;
    coc_far_model far (.*);
    coc_comparator_output_control #(.INSTR_DIV(4)) uut (.*);
    task automatic chk(input logic [4:0] seen, input logic [4:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %0t seen %b expected %b", $time, seen, exp);
        end
    endtask
    task automatic final_report;
        if (n_fail == 0 && check_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    // Bounded wait on result (g=0) or gate output (g=1)
    task automatic wait_for(input bit g, input logic e);
        int i;
        for (i = 0; i < 60 && (g ? gate_source : result_bit) !== e; i++) step(1);
        if (i == 60) begin
            chk(1, 0);
            final_report();
        end
    endtask
    task automatic flip(input logic v, input logic f);
        @(posedge sys_clk);
        invert_select <= v;
        wait_for(0, v);
        step(3);
        chk(comparator_event_flag, f);
    endtask
    initial begin
        repeat (6) @(posedge sys_clk);
        rst_n <= 1;
        #1 chk({result_bit, comparator_event_flag, gate_source, analog_enable}, 0);
        foreach (rows[k]) begin
            logic e;
            e = rows[k][0];
            @(posedge sys_clk);
            {comparator_enable_bit, invert_select, level} <= rows[k][3:1];
            wait_for(0, e);
            step(8);
            chk({pin_oe, pin_out, gate_source, shared_result_register}, {1'b1, e, e, 1'b0, e});
            chk({analog_enable, analog_hysteresis}, {2{rows[k][3]}});
        end
        chk(comparator_event_flag, 1);
        @(posedge sys_clk);
        flag_clear <= 1;
        @(posedge sys_clk);
        flag_clear <= 0;
        step(2);
        chk(comparator_event_flag, 0);
        flip(0, 0);
        @(posedge sys_clk);
        {falling_flag_enable, rising_flag_enable} <= 2'b10;
        flip(1, 0);
        flip(0, 1);
        @(posedge sys_clk);
        {flag_clear, invert_select} <= 2'b11;
        step(12);
        chk(comparator_event_flag, 0);
        @(posedge sys_clk);
        invert_select <= 0;
        for (int i = 0; i < 60 && comparator_event_flag !== 1; i++) step(1);
        chk(comparator_event_flag, 1);
        @(posedge sys_clk);
        flag_clear <= 0;
        @(posedge sys_clk);
        pin_direction_control <= 1;
        step(3);
        chk(pin_oe, 0);
        @(posedge sys_clk);
        {pin_direction_control, pin_output_selector} <= 6'h00;
        step(3);
        chk(pin_oe, 0);
        @(posedge sys_clk);
        {timer_sync_select, comparator_enable_bit} <= 2'b11;
        wait_for(0, 1);
        step(8);
        chk(gate_source, 0);
        @(posedge sys_clk);
        run_clk <= 1;
        wait_for(1, 1);
        chk(gate_source, 1);
        @(posedge sys_clk);
        rst_n <= 0;
        step(2);
        chk({result_bit, comparator_event_flag, gate_source, pin_oe, analog_hysteresis}, 0);
        final_report();
    end
endmodule
`default_nettype wire
